// >>> dfc_defs.svh
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DFC_OFS_CTRL   12'h40C
`define DFC_OFS_RAMCA  12'h424
`define DFC_OFS_RAMD   12'h428
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DFC_SRC_BIT    12
`define DFC_LVL_MSB    6
`define DFC_LVL_LSB    4
`define DFC_WID_MSB    3
`define DFC_WID_LSB    1
`define DFC_EN_BIT     0
`define DFC_ACC_BIT    7
`define DFC_UPD_BIT    6
`define DFC_ADR_MSB    5
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define DFC_CTRL_RST   32'h00000000
`define DFC_RAMCA_RST  32'h00000000
`define DFC_LVL_MAX    3'h4
`define DFC_WID_MIN    3'h1
`define DFC_WID_MAX    3'h5
`endif

// >>> dfc_pkg.sv
package dfc_pkg;
  typedef logic [2:0]  dfc_code_t;
  typedef logic [4:0]  dfc_field_t;
  typedef logic [31:0] dfc_word_t;
  typedef logic [5:0]  dfc_addr_t;
endpackage

// >>> dfc_cfg_if.sv
`timescale 1ns/100ps
interface dfc_cfg_if;
  dfc_pkg::dfc_code_t lvl;
  dfc_pkg::dfc_code_t wid;
  logic               en;
  modport ctl  (output lvl, output wid, output en);
  modport lane (input lvl, input wid, input en);
endinterface

// >>> dfc_lane.sv
`timescale 1ns/100ps
`include "dfc_defs.svh"
module dfc_lane #(
  parameter int CW = 6
) (
  dfc_cfg_if.lane              cfg,
  input  wire logic [CW-1:0]   colour,
  input  wire logic            pat_bit,
  output dfc_pkg::dfc_field_t  mod_bits,
  output dfc_pkg::dfc_field_t  dit_bits,
  output logic                 dit_out
);
  localparam logic [3:0] CW_L = 4'(CW);
  // ----------------------------------------------------------------
  // bit counts from the codes
  // ----------------------------------------------------------------
  wire       wid_ok = (cfg.wid >= `DFC_WID_MIN) && (cfg.wid <= `DFC_WID_MAX);
  // reserved level codes fall back to the widest split
  wire [3:0] n_mod  = (cfg.lvl > `DFC_LVL_MAX) ? 4'h5 : {1'b0, cfg.lvl} + 4'h1;
  wire [3:0] n_dit  = (cfg.en && wid_ok) ? 4'h6 - {1'b0, cfg.wid} : 4'h0;
  // ----------------------------------------------------------------
  // split of the colour value
  // ----------------------------------------------------------------
  wire [CW-1:0] mod_sh = colour >> (CW_L - n_mod);
  wire [CW-1:0] mask   = CW'((7'h01 << n_dit) - 7'h01);
  wire [CW-1:0] dit_v  = colour & mask;
  wire [3:0]    msb_ix = (n_dit == 4'h0) ? 4'h0 : n_dit - 4'h1;
  wire          msb    = (n_dit != 4'h0) && colour[msb_ix[2:0]];
  assign mod_bits = mod_sh[4:0];
  assign dit_bits = dit_v[4:0];
  // inverse pattern pairs share one stored matrix
  assign dit_out  = (n_dit != 4'h0) && (pat_bit ^ msb);
endmodule

// >>> dfc_top.sv
// Summary of operation
// - control bit 12 picks ROM patterns at 0 (reset), pattern RAM at 1.
// - pattern RAM writes pass only while the source select bit is 1.
// - level code 000..100 gives 1..5 most significant modulation bits.
// - width code 001..101 selects 5..1 dither bits; 000 is reserved.
// - dither bits are the low colour bits, modulation bits the high ones.
// - enable bit 0 clear turns dithering off; set dithers by width code.
// - pattern RAM reads and writes are refused unless dithering is on.
// - with dithering off, colour comes from frame rate modulation only.
// - pattern RAM sleeps when select is 0 and RAM bits 7:6 are 00.
// - pattern data is inverted when the pixel's top dither bit is 1.
// - the six-bit RAM address steps after every accepted data register access.
`timescale 1ns/100ps
`include "dfc_defs.svh"
module dfc_top #(
  parameter int CW = 6
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [11:0]          reg_addr,
  input  wire logic [31:0]          reg_wdata,
  output logic      [31:0]          reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic [31:0]          store_rdata,
  output dfc_pkg::dfc_addr_t        store_addr,
  output dfc_pkg::dfc_addr_t        store_waddr,
  output logic                      store_wr,
  output logic                      store_rd,
  output dfc_pkg::dfc_word_t        store_wdata,
  output logic                      store_ram_sel,
  output logic                      store_access_ok,
  output logic                      store_low_power,
  input  wire logic                 pix_valid,
  input  wire logic [3*CW-1:0]      pix_colour,
  input  wire logic [2:0]           pat_bits,
  output logic                      pix_out_valid,
  output logic      [14:0]          mod_out,
  output logic      [14:0]          dith_out,
  output logic      [2:0]           dith_bit
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic               src_q;
  dfc_pkg::dfc_code_t lvl_q;
  dfc_pkg::dfc_code_t wid_q;
  logic               en_q;
  logic               acc_q;
  logic               upd_q;
  dfc_pkg::dfc_addr_t store_addr_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire sel_ctrl  = (reg_addr == `DFC_OFS_CTRL);
  wire sel_ramca = (reg_addr == `DFC_OFS_RAMCA);
  wire sel_ramd  = (reg_addr == `DFC_OFS_RAMD);
  wire wr_ctrl   = reg_wr && sel_ctrl;
  wire wr_ramca  = reg_wr && sel_ramca;
  wire read_ok   = en_q && acc_q && upd_q;
  wire write_ok  = read_ok && src_q;
  wire ram_rd    = reg_rd && sel_ramd && read_ok;
  wire ram_wr    = reg_wr && sel_ramd && write_ok;
  wire ram_acc   = ram_rd || ram_wr;

  wire [31:0] ctrl_word  = {19'h0, src_q, 5'h0, lvl_q, wid_q, en_q};
  wire [31:0] ramca_word = {24'h0, acc_q, upd_q, store_addr_q};
  // refused data reads answer zero rather than stale RAM contents
  wire [31:0] ramd_word  = ram_rd ? store_rdata : 32'h00000000;
  wire [31:0] rdata_d    = sel_ctrl  ? ctrl_word :
                           sel_ramca ? ramca_word :
                           sel_ramd  ? ramd_word : 32'h00000000;
  wire        lp_d       = !src_q && !acc_q && !upd_q;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_q <= 1'(`DFC_CTRL_RST >> `DFC_SRC_BIT);
      lvl_q <= 3'(`DFC_CTRL_RST >> `DFC_LVL_LSB);
      wid_q <= 3'(`DFC_CTRL_RST >> `DFC_WID_LSB);
      en_q  <= 1'(`DFC_CTRL_RST >> `DFC_EN_BIT);
    end else if (wr_ctrl) begin
      src_q <= reg_wdata[`DFC_SRC_BIT];
      lvl_q <= reg_wdata[`DFC_LVL_MSB:`DFC_LVL_LSB];
      wid_q <= reg_wdata[`DFC_WID_MSB:`DFC_WID_LSB];
      en_q  <= reg_wdata[`DFC_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // RAM control and address register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q        <= 1'(`DFC_RAMCA_RST >> `DFC_ACC_BIT);
      upd_q        <= 1'(`DFC_RAMCA_RST >> `DFC_UPD_BIT);
      store_addr_q <= 6'(`DFC_RAMCA_RST);
    end else if (wr_ramca) begin
      acc_q        <= reg_wdata[`DFC_ACC_BIT];
      upd_q        <= reg_wdata[`DFC_UPD_BIT];
      store_addr_q <= reg_wdata[`DFC_ADR_MSB:0];
    end else if (ram_acc) begin
      store_addr_q <= store_addr_q + 6'h01;
    end
  end
  assign store_addr = store_addr_q;

  // ----------------------------------------------------------------
  // bus answer and RAM strobes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata       <= 32'h00000000;
      reg_rvalid      <= 1'b0;
      store_wr        <= 1'b0;
      store_rd        <= 1'b0;
      store_wdata     <= 32'h00000000;
      store_waddr     <= 6'h00;
      store_ram_sel   <= 1'b0;
      store_access_ok <= 1'b0;
      store_low_power <= 1'b1;
    end else begin
      reg_rdata       <= reg_rd ? rdata_d : reg_rdata;
      reg_rvalid      <= reg_rd;
      store_wr        <= ram_wr;
      store_rd        <= ram_rd;
      store_wdata     <= ram_wr ? reg_wdata : store_wdata;
      store_waddr     <= ram_wr ? store_addr_q : store_waddr;
      store_ram_sel   <= src_q;
      store_access_ok <= read_ok;
      store_low_power <= lp_d;
    end
  end

  // ----------------------------------------------------------------
  // pixel lanes
  // ----------------------------------------------------------------
  dfc_cfg_if cfg ();
  assign cfg.lvl = lvl_q;
  assign cfg.wid = wid_q;
  assign cfg.en  = en_q;

  wire [14:0] mod_d;
  wire [14:0] dit_d;
  wire [2:0]  bit_d;
  for (genvar g = 0; g < 3; g++) begin : g_lane
    dfc_lane #(.CW(CW)) u_lane (
      .cfg      (cfg),
      .colour   (pix_colour[g*CW +: CW]),
      .pat_bit  (pat_bits[g]),
      .mod_bits (mod_d[g*5 +: 5]),
      .dit_bits (dit_d[g*5 +: 5]),
      .dit_out  (bit_d[g])
    );
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pix_out_valid <= 1'b0;
      mod_out       <= 15'h0000;
      dith_out      <= 15'h0000;
      dith_bit      <= 3'h0;
    end else begin
      pix_out_valid <= pix_valid;
      mod_out       <= mod_d;
      dith_out      <= dit_d;
      dith_bit      <= bit_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ctrl_write;
    wr_ctrl && !reg_rd;
  endsequence
  sequence s_ctrl_read;
    reg_rd && sel_ctrl && !reg_wr;
  endsequence

  chk_src_select: assert property (
    s_ctrl_write ##1 !wr_ctrl |=> store_ram_sel == $past(src_q))
    else $error("source select output does not follow register");
  chk_write_gate: assert property (
    store_wr |-> $past(src_q && en_q && acc_q && upd_q))
    else $error("pattern RAM written while not allowed");
  chk_level_split: assert property (
    lvl_q == 3'h2 && $stable(lvl_q) |=> mod_out[4:0] == {2'h0,
      $past(pix_colour[CW-1:CW-3])})
    else $error("modulation bits wrong for three bit level");
  chk_width_split: assert property (
    en_q && wid_q == 3'h3 |=> dith_out[4:0] == {2'h0, $past(pix_colour[2:0])})
    else $error("dither bits wrong for three bit width");
  chk_dis_nodith: assert property (
    !en_q |=> dith_out == 15'h0000 && dith_bit == 3'h0)
    else $error("dither output active while disabled");
  chk_read_gate: assert property (
    store_rd |-> $past(en_q && acc_q && upd_q))
    else $error("pattern RAM read while not allowed");
  chk_frm_only: assert property (
    !en_q && lvl_q == 3'h4 |=> mod_out[4:0] == $past(pix_colour[CW-1:1]))
    else $error("modulation path lost with dithering off");
  chk_low_power: assert property (
    !src_q && !acc_q && !upd_q ##1 $stable({src_q, acc_q, upd_q})
      |-> store_low_power)
    else $error("pattern RAM not in reduced power");
  chk_invert_msb: assert property (
    en_q && wid_q == 3'h5 |=> dith_bit[0] == ($past(pat_bits[0]) ^
      $past(pix_colour[0])))
    else $error("pattern inversion by dither msb wrong");
  chk_addr_step: assert property (
    ram_acc && !wr_ramca |=> store_addr_q == $past(store_addr_q) + 6'h01)
    else $error("RAM address did not step after access");
  chk_ctrl_readback: assert property (
    s_ctrl_read |=> reg_rvalid && reg_rdata[31:13] == 19'h0
      && reg_rdata[11:7] == 5'h0 && reg_rdata[12] == src_q)
    else $error("control readback wrong");
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
`include "dfc_defs.svh"
module testbench;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic               sys_clk = 1'b0, rst = 1'b1;
  logic               reg_wr = 1'b0, reg_rd = 1'b0, pix_valid = 1'b0;
  logic [11:0]        reg_addr = 12'h000;
  logic [31:0]        reg_wdata = 32'h00000000, reg_rdata, store_rdata;
  logic [17:0]        pix_colour = 18'h00000;
  logic [2:0]         pat_bits = 3'h0, dith_bit;
  logic [14:0]        mod_out, dith_out;
  logic               reg_rvalid, store_wr, store_rd, pix_out_valid;
  logic               store_ram_sel, store_access_ok, store_low_power;
  dfc_pkg::dfc_addr_t store_addr, store_waddr, a;
  dfc_pkg::dfc_word_t store_wdata, last_wd, wd;
  logic [32:0]        rd_q[$], px_q[$];
  int                 n_fail = 0, checked = 0, n_wr = 0, cycles = 0;
  int                 n_rd = 0;
  int                 cur_lvl, cur_wid;
  logic               cur_en;

  dfc_top #(.CW(6)) i_dfc_top (.sys_clk(sys_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .store_rdata(store_rdata), .store_addr(store_addr),
    .store_waddr(store_waddr), .store_wr(store_wr), .store_rd(store_rd),
    .store_wdata(store_wdata), .store_ram_sel(store_ram_sel),
    .store_access_ok(store_access_ok), .store_low_power(store_low_power),
    .pix_valid(pix_valid), .pix_colour(pix_colour), .pat_bits(pat_bits),
    .pix_out_valid(pix_out_valid), .mod_out(mod_out),
    .dith_out(dith_out), .dith_bit(dith_bit));

  // ----------------------------------------------------------------
  // pattern store stand-in: contents are a function of the address
  // ----------------------------------------------------------------
  function automatic logic [31:0] ram_word(input logic [5:0] x);
    return {~x, 20'h5A5A5, x};
  endfunction
  assign store_rdata = ram_word(store_addr);

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a read notes its expected word; bus raises one strobe and lowers the other, idle lowers both
  task automatic bus(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= ad;
    reg_wdata <= w ? d : 32'($urandom);
    if (!w) rd_q.push_back({1'b0, d});
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      pix_valid <= 1'b0;
    end
    @(negedge sys_clk);
  endtask

  task automatic pix();
    logic [17:0] col;
    logic [2:0]  pat;
    logic [32:0] e;
    logic [5:0]  c;
    int          n;
    col = 18'($urandom);
    pat = 3'($urandom);
    n = cur_en ? 6 - cur_wid : 0;
    for (int i = 0; i < 3; i++) begin
      c = col[6*i +: 6];
      e[18+5*i +: 5] = 5'(c >> (5 - cur_lvl));
      e[3+5*i +: 5] = 5'(c & ((6'h01 << n) - 6'h01));
      e[i] = (n == 0) ? 1'b0 : pat[i] ^ c[n-1];
    end
    @(posedge sys_clk);
    pix_valid <= 1'b1;
    pix_colour <= col;
    pat_bits <= pat;
    px_q.push_back(e);
  endtask

  // ----------------------------------------------------------------
  // output watcher: oldest note against each answer
  // ----------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (reg_rvalid === 1'b1)
      chk(reg_rdata, rd_q.size() ? rd_q.pop_front() : 33'h1FFFFFFFF,
          "rd");
    if (pix_out_valid === 1'b1)
      chk({mod_out, dith_out, dith_bit},
          px_q.size() ? px_q.pop_front() : 33'h1FFFFFFFF, "pixel");
    if (store_rd === 1'b1)
      n_rd++;
    if (store_wr === 1'b1) begin
      n_wr++;
      last_wd = store_wdata;
      chk(33'(store_waddr), 33'h3F, "store write address");
    end
  end

  // limit well above the roughly 140 cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h52DD));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    idle(1);
    chk(store_low_power, 1'b1, "sleep after reset");
    chk(store_ram_sel, 1'b0, "source after reset");
    chk(store_access_ok, 1'b0, "access closed after reset");
    bus(1'b0, `DFC_OFS_CTRL, 32'h00000000);
    bus(1'b0, `DFC_OFS_RAMCA, 32'h00000000);
    bus(1'b0, 12'h400, 32'h00000000);
    bus(1'b1, `DFC_OFS_CTRL, 32'hFFFFEFCA);
    bus(1'b0, `DFC_OFS_CTRL, 32'h0000004A);
    bus(1'b1, `DFC_OFS_RAMCA, 32'hFFFFFFC5);
    bus(1'b0, `DFC_OFS_RAMD, 32'h00000000);
    bus(1'b0, `DFC_OFS_RAMCA, 32'h000000C5);
    bus(1'b1, `DFC_OFS_CTRL, 32'h0000004B);
    bus(1'b1, `DFC_OFS_RAMD, 32'($urandom));
    a = 6'h05;
    repeat (2) begin
      bus(1'b0, `DFC_OFS_RAMD, ram_word(a));
      a++;
    end
    bus(1'b0, `DFC_OFS_RAMCA, 32'h000000C7);
    idle(3);
    chk(33'(n_wr), 33'h0, "writes refused");
    chk(store_access_ok, 1'b1, "access open");
    chk(33'(n_rd), 33'h2, "accepted store reads");
    chk(33'(store_addr), 33'h07, "address after two reads");
    chk(store_low_power, 1'b0, "awake with access bits");
    $display("test store access done");
    bus(1'b1, `DFC_OFS_CTRL, 32'h0000104B);
    bus(1'b1, `DFC_OFS_RAMCA, 32'h000000FF);
    wd = 32'($urandom);
    bus(1'b1, `DFC_OFS_RAMD, wd);
    bus(1'b0, `DFC_OFS_RAMCA, 32'h000000C0);
    idle(3);
    chk(store_ram_sel, 1'b1, "source pattern store");
    chk(33'(n_wr), 33'h1, "write count");
    chk(33'(last_wd), 33'(wd), "write data");
    bus(1'b1, `DFC_OFS_CTRL, 32'h0000004B);
    bus(1'b1, `DFC_OFS_RAMCA, 32'h00000040);
    idle(4);
    chk(store_low_power, 1'b0, "awake with one access bit");
    bus(1'b1, `DFC_OFS_RAMCA, 32'h00000000);
    idle(4);
    chk(store_low_power, 1'b1, "sleep when deselected");
    $display("test source and sleep done");
    for (int en = 0; en < 2; en++) begin
      for (int k = 0; k < 5; k++) begin
        cur_lvl = k;
        cur_wid = k + 1;
        cur_en = 1'(en);
        bus(1'b1, `DFC_OFS_CTRL, 32'(k << 4 | (k + 1) << 1 | en));
        idle(3);
        repeat (4) pix();
        idle(2);
      end
    end
    $display("test pixel split done");
    idle(3);
    chk(33'(rd_q.size() + px_q.size()), 33'h0, "answers missing");
    finish_test();
  end
endmodule
